// file: design/pmrc_defines.svh
// named offsets, field positions, reset values and timing counts of the power and reset controller
// assumes byte addresses on a 12-bit register port with 32-bit data
`ifndef PMRC_DEFINES_SVH
`define PMRC_DEFINES_SVH

`define PMRC_AW              12
`define PMRC_DW              32

// register offsets
`define PMRC_OFF_TASK_CLAT   12'h078
`define PMRC_OFF_TASK_LPWR   12'h07c
`define PMRC_OFF_EVT_WARN    12'h108
`define PMRC_OFF_PINSEL      12'h200
`define PMRC_OFF_CAUSE       12'h400
`define PMRC_OFF_SYSOFF      12'h500
`define PMRC_OFF_FAILCFG     12'h510
`define PMRC_OFF_GPRET       12'h51c
`define PMRC_OFF_STATUS      12'h600
`define PMRC_RAM_PAGE        4'h9
`define PMRC_RAM_LOW         4'h0

// reset cause bits
`define PMRC_CAUSE_PIN       0
`define PMRC_CAUSE_DOG       1
`define PMRC_CAUSE_SOFT      2
`define PMRC_CAUSE_LOCKUP    3
`define PMRC_CAUSE_WAKE      16

// comparator configuration fields
`define PMRC_FAIL_EN         0
`define PMRC_FAIL_THR_LO     1
`define PMRC_FAIL_THR_HI     4

// reset pin select fields
`define PMRC_PINSEL_LO       0
`define PMRC_PINSEL_HI       4
`define PMRC_PINSEL_OFF      31
`define PMRC_PINSEL_RST      32'h8000_0000

// ram section control fields
`define PMRC_RAM_PWR         0
`define PMRC_RAM_RET         16

// status fields
`define PMRC_ST_CLAT         0
`define PMRC_ST_CMP          1
`define PMRC_ST_BELOW        2
`define PMRC_ST_OFF          3

// reset target bits
`define PMRC_TGT_CPU         0
`define PMRC_TGT_PERIPH      1
`define PMRC_TGT_GPIO        2
`define PMRC_TGT_DEBUG       3
`define PMRC_TGT_SWJ         4
`define PMRC_TGT_WDT         5
`define PMRC_TGT_RETAIN      6
`define PMRC_TGT_W           7

// timing
`define PMRC_CLK_NS          10
`define PMRC_RST_HOLD_NS     100
`define PMRC_RST_HOLD_CYC    ((`PMRC_RST_HOLD_NS + `PMRC_CLK_NS - 1) / `PMRC_CLK_NS)
`define PMRC_CNT_W           8

`endif

// file: design/pmrc_pkg.sv
// types shared by the power and reset controller
// assumes pmrc_defines.svh is on the include path
`include "pmrc_defines.svh"

package pmrc_pkg;
  typedef enum logic {
    st_run,
    st_hold
  } pmrc_seq_t;

  typedef logic [`PMRC_TGT_W-1:0] pmrc_tgt_t;
endpackage

// file: design/pmrc_sync.sv
// three-stage synchroniser for a vector of asynchronous levels
// assumes every bit is independent; a bit changes once stages two and three agree
`timescale 1ns/1ps

module pmrc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] rst_val,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] out_ff;
  logic [WIDTH-1:0] agree;
  logic [1:0]       fill_ff;
  logic             filled;

  assign agree    = ~(s2_ff ^ s3_ff);
  assign filled   = &fill_ff;
  assign sync_out = out_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // reset loads zero, then idle values stand from the first clock until stages two and three hold real samples
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_ff  <= '0;
      fill_ff <= 2'h0;
    end else begin
      fill_ff <= filled ? fill_ff : fill_ff + 2'h1;
      out_ff  <= filled ? ((agree & s3_ff) | (~agree & out_ff)) : rst_val;
    end
  end
endmodule

// file: design/pmrc_top.sv
// power mode, supply supervisor, ram power and reset control
// assumes analog supply flags and pins arrive asynchronously; core, watchdog and debug signals share clk
`timescale 1ns/1ps
`include "pmrc_defines.svh"

module pmrc_top #(
  parameter int          PINS          = 8,
  parameter int          SECTIONS      = 4,
  parameter int          GPRET_W       = 8,
  parameter logic [31:0] RST_PIN_OK    = 32'h0000_00f0,
  parameter int          RST_HOLD_CYC  = `PMRC_RST_HOLD_CYC
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // register port
  input  wire logic [`PMRC_AW-1:0]   reg_addr,
  input  wire logic [`PMRC_DW-1:0]   reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [`PMRC_DW-1:0]   reg_rdata,
  // asynchronous supply flags and pins
  input  wire logic                  supply_ok,
  input  wire logic                  supply_below_warn,
  input  wire logic                  supply_below_brownout,
  input  wire logic                  pin_detect,
  input  wire logic [PINS-1:0]       gpio_pins,
  // core, watchdog and debug
  input  wire logic                  system_reset_request,
  input  wire logic                  control_access_port_reset,
  input  wire logic                  watchdog_timeout,
  input  wire logic                  cpu_lockup,
  input  wire logic                  debug_mode,
  input  wire logic                  high_speed_clock_running,
  input  wire logic                  cpu_idle,
  input  wire logic                  periph_idle,
  // power mode and supervisor
  output logic                       constant_latency_active,
  output logic                       supply_warning_event,
  output logic                       comparator_active,
  output logic [3:0]                 warning_threshold,
  output logic                       nonvolatile_write_block,
  output logic                       system_off,
  // ram sections
  output logic [SECTIONS-1:0]        ram_accessible,
  output logic [SECTIONS-1:0]        ram_retained,
  // reset targets, active low
  output logic                       cpu_rst_n,
  output logic                       periph_rst_n,
  output logic                       gpio_rst_n,
  output logic                       debug_rst_n,
  output logic                       serial_debug_port_rst_n,
  output logic                       watchdog_timer_rst_n
);
  localparam int SW = PINS + 4;
  localparam int RW = $clog2(SECTIONS > 1 ? SECTIONS : 2);

  // synchronised inputs
  logic [SW-1:0] sync_v;
  logic [PINS-1:0] pins_s;
  logic          ok_s;
  logic          below_s;
  logic          bor_s;
  logic          detect_s;

  pmrc_sync #(
    .WIDTH(SW)
  ) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in ({supply_ok, supply_below_warn, supply_below_brownout, pin_detect, gpio_pins}),
    .rst_val  ({1'b0, 1'b0, 1'b0, 1'b0, {PINS{1'b1}}}),
    .sync_out (sync_v)
  );

  assign pins_s   = sync_v[PINS-1:0];
  assign detect_s = sync_v[PINS];
  assign bor_s    = sync_v[PINS+1];
  assign below_s  = sync_v[PINS+2];
  assign ok_s     = sync_v[PINS+3];

  // state
  logic                       mode_clat_ff;
  logic                       off_ff;
  logic                       fail_en_ff;
  logic [3:0]                 fail_thr_ff;
  logic                       evt_warn_ff;
  logic                       warn_prev_ff;
  logic                       warn_pulse_ff;
  logic                       cmp_ff;
  logic                       nvm_blk_ff;
  logic                       clat_act_ff;
  logic [31:0]                pinsel_ff;
  logic [31:0]                cause_ff;
  logic [GPRET_W-1:0]         gpret_ff;
  logic [SECTIONS-1:0]        ram_pwr_ff;
  logic [SECTIONS-1:0]        ram_ret_ff;
  logic [SECTIONS-1:0]        ram_acc_ff;
  logic [SECTIONS-1:0]        ram_kept_ff;
  logic [`PMRC_DW-1:0]        rdata_ff;
  pmrc_pkg::pmrc_tgt_t        tgt_ff;
  pmrc_pkg::pmrc_seq_t        seq_ff;
  logic [`PMRC_CNT_W-1:0]     cnt_ff;

  // address decode
  wire                 wr_clat   = reg_wr && (reg_addr == `PMRC_OFF_TASK_CLAT);
  wire                 wr_lpwr   = reg_wr && (reg_addr == `PMRC_OFF_TASK_LPWR);
  wire                 wr_evt    = reg_wr && (reg_addr == `PMRC_OFF_EVT_WARN);
  wire                 wr_pinsel = reg_wr && (reg_addr == `PMRC_OFF_PINSEL);
  wire                 wr_cause  = reg_wr && (reg_addr == `PMRC_OFF_CAUSE);
  wire                 wr_sysoff = reg_wr && (reg_addr == `PMRC_OFF_SYSOFF);
  wire                 wr_fail   = reg_wr && (reg_addr == `PMRC_OFF_FAILCFG);
  wire                 wr_gpret  = reg_wr && (reg_addr == `PMRC_OFF_GPRET);
  wire [RW-1:0]        ram_idx   = reg_addr[4+RW-1:4];
  wire                 ram_hit   = (reg_addr[11:8] == `PMRC_RAM_PAGE) && (reg_addr[3:0] == `PMRC_RAM_LOW)
                                   && (32'(reg_addr[7:4]) < SECTIONS);

  // reset sources
  wire [4:0] pin_no     = pinsel_ff[`PMRC_PINSEL_HI:`PMRC_PINSEL_LO];
  wire       pin_ok     = !pinsel_ff[`PMRC_PINSEL_OFF] && RST_PIN_OK[pin_no]
                          && (32'(pin_no) < PINS);
  wire       src_pin    = pin_ok && !pins_s[pin_no[$clog2(PINS)-1:0]];
  wire       src_power  = !ok_s || bor_s;
  wire       src_soft   = system_reset_request || control_access_port_reset;
  wire       src_dog    = watchdog_timeout && !off_ff;
  wire       src_lockup = cpu_lockup && !debug_mode && !off_ff;
  wire       src_wake   = off_ff && detect_s;
  wire       any_src    = src_pin || src_power || src_soft || src_dog || src_lockup || src_wake;
  wire       clr_retain = src_pin || src_power || src_dog;

  // reset target masks; the supply warning feeds none of them
  pmrc_pkg::pmrc_tgt_t m_full;
  pmrc_pkg::pmrc_tgt_t m_pin_dog;
  pmrc_pkg::pmrc_tgt_t m_wake;
  pmrc_pkg::pmrc_tgt_t m_core;
  pmrc_pkg::pmrc_tgt_t nxt_mask;

  assign m_full    = '1;
  assign m_pin_dog = m_full & ~(pmrc_pkg::pmrc_tgt_t'(1) << `PMRC_TGT_SWJ);
  assign m_core    = (pmrc_pkg::pmrc_tgt_t'(1) << `PMRC_TGT_CPU)
                   | (pmrc_pkg::pmrc_tgt_t'(1) << `PMRC_TGT_PERIPH)
                   | (pmrc_pkg::pmrc_tgt_t'(1) << `PMRC_TGT_GPIO);
  assign m_wake    = (pmrc_pkg::pmrc_tgt_t'(1) << `PMRC_TGT_CPU)
                   | (pmrc_pkg::pmrc_tgt_t'(1) << `PMRC_TGT_PERIPH)
                   | (pmrc_pkg::pmrc_tgt_t'(1) << `PMRC_TGT_WDT)
                   | (pmrc_pkg::pmrc_tgt_t'(!debug_mode) << `PMRC_TGT_DEBUG);
  assign nxt_mask  = (src_power ? m_full : '0)
                   | ((src_pin || src_dog) ? m_pin_dog : '0)
                   | (src_wake ? m_wake : '0)
                   | ((src_soft || src_lockup) ? m_core : '0);

  // reset sequencer: a source stretches its targets for a fixed hold time
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tgt_ff <= '1;
      seq_ff <= pmrc_pkg::st_hold;
      cnt_ff <= `PMRC_CNT_W'(RST_HOLD_CYC);
    end else if (any_src) begin
      tgt_ff <= tgt_ff | nxt_mask;
      seq_ff <= pmrc_pkg::st_hold;
      cnt_ff <= `PMRC_CNT_W'(RST_HOLD_CYC);
    end else begin
      case (seq_ff)
        pmrc_pkg::st_hold: begin
          if (cnt_ff == '0) begin
            tgt_ff <= '0;
            seq_ff <= pmrc_pkg::st_run;
          end else begin
            cnt_ff <= cnt_ff - `PMRC_CNT_W'(1);
          end
        end
        default: begin
          seq_ff <= pmrc_pkg::st_run;
        end
      endcase
    end
  end

  // reset cause: sources other than power set bits and power clears them all; software writes ones to clear, set wins
  wire [31:0] cause_set = (32'(src_pin) << `PMRC_CAUSE_PIN)
                        | (32'(src_dog) << `PMRC_CAUSE_DOG)
                        | (32'(src_soft) << `PMRC_CAUSE_SOFT)
                        | (32'(src_lockup) << `PMRC_CAUSE_LOCKUP)
                        | (32'(src_wake) << `PMRC_CAUSE_WAKE);
  wire [31:0] cause_clr = wr_cause ? reg_wdata : 32'h0000_0000;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cause_ff <= 32'h0000_0000;
    end else if (src_power) begin
      cause_ff <= 32'h0000_0000;
    end else begin
      cause_ff <= (cause_ff & ~cause_clr) | cause_set;
    end
  end

  // sub power mode and System OFF; any reset re-enters System ON in low-power mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_clat_ff <= 1'b0;
      off_ff       <= 1'b0;
    end else if (any_src) begin
      mode_clat_ff <= 1'b0;
      off_ff       <= 1'b0;
    end else begin
      if (wr_clat && reg_wdata[0]) begin
        mode_clat_ff <= 1'b1;
      end else if (wr_lpwr && reg_wdata[0]) begin
        mode_clat_ff <= 1'b0;
      end
      if (wr_sysoff && reg_wdata[0]) begin
        off_ff <= 1'b1;
      end
    end
  end

  // comparator configuration, a peripheral register cleared by every reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fail_en_ff  <= 1'b0;
      fail_thr_ff <= 4'h0;
    end else if (any_src) begin
      fail_en_ff  <= 1'b0;
      fail_thr_ff <= 4'h0;
    end else if (wr_fail) begin
      fail_en_ff  <= reg_wdata[`PMRC_FAIL_EN];
      fail_thr_ff <= reg_wdata[`PMRC_FAIL_THR_HI:`PMRC_FAIL_THR_LO];
    end
  end

  // the analog side compares against warning_threshold, so a raised threshold or a fresh
  // enable with the supply already low shows up as a new rising edge of warn_now
  wire nxt_cmp  = fail_en_ff && high_speed_clock_running && !off_ff;
  wire warn_now = cmp_ff && below_s;
  wire warn_hit = warn_now && !warn_prev_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmp_ff        <= 1'b0;
      warn_prev_ff  <= 1'b0;
      warn_pulse_ff <= 1'b0;
      nvm_blk_ff    <= 1'b0;
    end else begin
      cmp_ff        <= nxt_cmp;
      warn_prev_ff  <= warn_now;
      warn_pulse_ff <= warn_hit;
      nvm_blk_ff    <= fail_en_ff && nxt_cmp && below_s;
    end
  end

  // sticky warning event, cleared by writing zero; a new event wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evt_warn_ff <= 1'b0;
    end else if (warn_hit) begin
      evt_warn_ff <= 1'b1;
    end else if (any_src || (wr_evt && !reg_wdata[0])) begin
      evt_warn_ff <= 1'b0;
    end
  end

  // retained registers: ram section control, pin select and general purpose byte
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gpret_ff  <= '0;
      pinsel_ff <= `PMRC_PINSEL_RST;
    end else if (clr_retain) begin
      gpret_ff  <= '0;
      pinsel_ff <= `PMRC_PINSEL_RST;
    end else begin
      if (wr_gpret) begin
        gpret_ff <= reg_wdata[GPRET_W-1:0];
      end
      if (wr_pinsel) begin
        pinsel_ff <= reg_wdata;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < SECTIONS; g++) begin : g_ram
      wire hit = ram_hit && (ram_idx == RW'(g));

      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          ram_pwr_ff[g] <= 1'b1;
          ram_ret_ff[g] <= 1'b0;
        end else if (clr_retain) begin
          ram_pwr_ff[g] <= 1'b1;
          ram_ret_ff[g] <= 1'b0;
        end else if (reg_wr && hit) begin
          ram_pwr_ff[g] <= reg_wdata[`PMRC_RAM_PWR];
          ram_ret_ff[g] <= reg_wdata[`PMRC_RAM_RET];
        end
      end

      // ram contents are only ever gated, never cleared
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          ram_acc_ff[g]  <= 1'b0;
          ram_kept_ff[g] <= 1'b0;
        end else begin
          ram_acc_ff[g]  <= !off_ff && ram_pwr_ff[g];
          ram_kept_ff[g] <= off_ff ? ram_ret_ff[g]
                                   : (ram_pwr_ff[g] || ram_ret_ff[g]);
        end
      end
    end
  endgenerate

  // mode only matters while everything sleeps
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clat_act_ff <= 1'b0;
    end else begin
      clat_act_ff <= mode_clat_ff && cpu_idle && periph_idle && !off_ff;
    end
  end

  // read mux; unmapped addresses read zero
  wire [31:0] ram_word = {15'h0000, ram_ret_ff[ram_idx], 15'h0000, ram_pwr_ff[ram_idx]};
  wire [31:0] st_word  = (32'(mode_clat_ff) << `PMRC_ST_CLAT) | (32'(cmp_ff) << `PMRC_ST_CMP)
                       | (32'(below_s) << `PMRC_ST_BELOW) | (32'(off_ff) << `PMRC_ST_OFF);
  logic [31:0] rmux;

  always_comb begin
    rmux = 32'h0000_0000;
    case (reg_addr)
      `PMRC_OFF_EVT_WARN: rmux = 32'(evt_warn_ff);
      `PMRC_OFF_PINSEL:   rmux = pinsel_ff;
      `PMRC_OFF_CAUSE:    rmux = cause_ff;
      `PMRC_OFF_SYSOFF:   rmux = 32'(off_ff);
      `PMRC_OFF_FAILCFG:  rmux = (32'(fail_thr_ff) << `PMRC_FAIL_THR_LO) | 32'(fail_en_ff);
      `PMRC_OFF_GPRET:    rmux = 32'(gpret_ff);
      `PMRC_OFF_STATUS:   rmux = st_word;
      default:            rmux = ram_hit ? ram_word : 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= reg_rd ? rmux : '0;
    end
  end

  // outputs
  assign reg_rdata               = rdata_ff;
  assign constant_latency_active = clat_act_ff;
  assign supply_warning_event    = warn_pulse_ff;
  assign comparator_active       = cmp_ff;
  assign warning_threshold       = fail_thr_ff;
  assign nonvolatile_write_block = nvm_blk_ff;
  assign system_off              = off_ff;
  assign ram_accessible          = ram_acc_ff;
  assign ram_retained            = ram_kept_ff;
  assign cpu_rst_n               = !tgt_ff[`PMRC_TGT_CPU];
  assign periph_rst_n            = !tgt_ff[`PMRC_TGT_PERIPH];
  assign gpio_rst_n              = !tgt_ff[`PMRC_TGT_GPIO];
  assign debug_rst_n             = !tgt_ff[`PMRC_TGT_DEBUG];
  assign serial_debug_port_rst_n = !tgt_ff[`PMRC_TGT_SWJ];
  assign watchdog_timer_rst_n    = !tgt_ff[`PMRC_TGT_WDT];
endmodule

// file: bench/pmrc_top_props.sv
// port assertions for the power and reset controller
// assumes one clock domain; bound to every pmrc_top at the foot
`timescale 1ns/1ps
module pmrc_top_props #(
  parameter int RST_HOLD_CYC = 10,
  parameter int SECTIONS     = 4
) (
  // clock and reset
  input wire logic                clk,
  input wire logic                resetn,
  // sources and conditions
  input wire logic                watchdog_timeout,
  input wire logic                system_reset_request,
  input wire logic                cpu_lockup,
  input wire logic                debug_mode,
  input wire logic                cpu_idle,
  input wire logic                high_speed_clock_running,
  // observed outputs
  input wire logic                supply_warning_event,
  input wire logic                comparator_active,
  input wire logic                constant_latency_active,
  input wire logic                system_off,
  input wire logic [SECTIONS-1:0] ram_accessible,
  input wire logic                cpu_rst_n,
  input wire logic                periph_rst_n,
  input wire logic                gpio_rst_n,
  input wire logic                watchdog_timer_rst_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // saturates so a long brownout cannot wrap into a short count
  logic [7:0] low_run_ff;
  logic [7:0] nxt_low_run;
  assign nxt_low_run = cpu_rst_n ? 8'h00 : ((low_run_ff == 8'hff) ? low_run_ff : low_run_ff + 8'h01);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) low_run_ff <= 8'h00;
    else low_run_ff <= nxt_low_run;
  end
  sequence s_core_rst;
    !cpu_rst_n && !periph_rst_n && !gpio_rst_n;
  endsequence
  a_soft_core_rst: assert property (system_reset_request |=> s_core_rst)
    else $error("soft request left the core running");
  a_lockup_core_rst: assert property (cpu_lockup && !debug_mode && !system_off |=> s_core_rst)
    else $error("lockup left the core running");
  a_dog_rst: assert property (watchdog_timeout && !system_off |=> !cpu_rst_n && !watchdog_timer_rst_n)
    else $error("watchdog timeout gave no reset");
  a_warn_pulse: assert property (supply_warning_event |=> !supply_warning_event)
    else $error("warning event longer than one cycle");
  a_cmp_idle: assert property (!high_speed_clock_running || system_off |=> !comparator_active)
    else $error("comparator active without clock or in off");
  a_mode_idle: assert property (!cpu_idle || system_off |=> !constant_latency_active)
    else $error("constant latency while busy or off");
  a_off_ram: assert property (system_off ##1 system_off |-> ram_accessible == '0)
    else $error("ram accessible in off");
  a_hold_len: assert property ($rose(cpu_rst_n) |-> low_run_ff >= RST_HOLD_CYC + 1)
    else $error("core reset released too early");
endmodule

bind pmrc_top pmrc_top_props #(.RST_HOLD_CYC(RST_HOLD_CYC), .SECTIONS(SECTIONS)) pmrc_top_props_inst (.*);

// file: bench/pmrc_far_model.sv
// far side: core, access port and watchdog raising reset requests
// assumes one-cycle kick pulses from the bench, except the lockup kick that is held for several cycles in debug mode
`timescale 1ns/1ps
module pmrc_far_model (
  // clock
  input wire logic       clk,
  // kick: bit0 core request, bit1 access port, bit2 watchdog, bit3 lockup
  input wire logic [3:0] kick,
  // targets seen by the far side
  input wire logic       cpu_rst_n,
  input wire logic       watchdog_timer_rst_n,
  // requests
  output logic           system_reset_request,
  output logic           control_access_port_reset,
  output logic           watchdog_timeout,
  output logic           cpu_lockup
);
  logic [3:0] req_ff = 4'h0;
  // a request stands until its own target is reset, as real sources do
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      req_ff[i] <= kick[i] | (req_ff[i] & ((i == 2) ? watchdog_timer_rst_n : cpu_rst_n));
    end
  end
  assign system_reset_request      = req_ff[0];
  assign control_access_port_reset = req_ff[1];
  assign watchdog_timeout          = req_ff[2];
  assign cpu_lockup                = req_ff[3];
endmodule

// file: bench/pmrc_top_tb_top.sv
// self-checking bench for the power and reset controller
// assumes the far model drives core requests; supply_ok stays high
`timescale 1ns/1ps
module pmrc_top_tb_top;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d;} pmrc_row_t;
  logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, supply_ok = 1'b1;
  logic supply_below_warn = 1'b0, supply_below_brownout = 1'b0, pin_detect = 1'b0, debug_mode = 1'b0;
  logic high_speed_clock_running = 1'b1, cpu_idle = 1'b1, periph_idle = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [7:0] gpio_pins = 8'hff;
  logic [3:0] kick = 4'h0, warning_threshold, ram_accessible, ram_retained;
  logic system_reset_request, control_access_port_reset, watchdog_timeout, cpu_lockup;
  logic constant_latency_active, supply_warning_event, comparator_active, nonvolatile_write_block, system_off;
  logic cpu_rst_n, periph_rst_n, gpio_rst_n, debug_rst_n, serial_debug_port_rst_n, watchdog_timer_rst_n;
  int n_mismatch = 0, comparisons = 0, cycles = 0;
  pmrc_row_t rows [10] = '{'{1'b0, 12'h400, 32'h0}, '{1'b0, 12'h200, 32'h8000_0000}, '{1'b0, 12'h900, 32'h1},
    '{1'b0, 12'h800, 32'h0}, '{1'b1, 12'h51c, 32'h5a}, '{1'b0, 12'h51c, 32'h5a}, '{1'b1, 12'h078, 32'h1},
    '{1'b0, 12'h600, 32'h1}, '{1'b1, 12'h07c, 32'h1}, '{1'b0, 12'h600, 32'h0}};
  pmrc_top #(.RST_HOLD_CYC(2)) pmrc_top_inst (.*);
  pmrc_far_model pmrc_far_model_inst (.*);
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(what, reg_rdata, exp);
  endtask
  // polled at the falling edge so the pulse is read settled
  task automatic wait_for(input int sel, input logic lvl, input int n);
    int k;
    k = 0;
    while ((sel == 0 ? supply_warning_event : cpu_rst_n) !== lvl && k < n) begin
      @(negedge clk);
      k++;
    end
    chk(sel == 0 ? "warning event" : "core reset", sel == 0 ? supply_warning_event : cpu_rst_n, lvl);
  endtask
  task automatic pulse(input logic [3:0] k);
    @(posedge clk);
    kick <= k;
    @(posedge clk);
    kick <= 4'h0;
    wait_for(1, 1'b0, 20);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    wait_for(1, 1'b1, 60);
    chk("off after power-on", system_off, 0);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rdchk("register row", rows[i].a, rows[i].d);
    end
    wr(12'h078, 32'h1);
    repeat (2) @(negedge clk);
    chk("constant latency", constant_latency_active, 1);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      cpu_idle <= (i == 1);
      periph_idle <= (i == 0);
      repeat (2) @(negedge clk);
      chk("mode while busy", constant_latency_active, 0);
    end
    @(posedge clk);
    periph_idle <= 1'b1;
    wr(12'h510, 32'h0b);
    supply_below_warn <= 1'b1;
    wait_for(0, 1'b1, 12);
    @(negedge clk);
    chk("threshold", warning_threshold, 4'h5);
    chk("write block", nonvolatile_write_block, 1);
    chk("no reset from warning", cpu_rst_n, 1);
    rdchk("event bit", 12'h108, 32'h1);
    wr(12'h108, 32'h0);
    high_speed_clock_running <= 1'b0;
    repeat (6) @(negedge clk);
    chk("comparator idle", comparator_active, 0);
    @(posedge clk);
    high_speed_clock_running <= 1'b1;
    wait_for(0, 1'b1, 12);
    @(posedge clk);
    supply_below_warn <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      pulse((i == 0) ? 4'h1 : 4'h2);
      chk("soft spares wdt", watchdog_timer_rst_n, 1);
      wait_for(1, 1'b1, 60);
      rdchk("soft cause", 12'h400, 32'h4);
      rdchk("mode default", 12'h600, 32'h0);
      rdchk("retained kept", 12'h51c, 32'h5a);
      wr(12'h400, 32'hffff_ffff);
    end
    debug_mode <= 1'b1;
    kick <= 4'h8;
    repeat (6) @(negedge clk);
    chk("lockup in debug", cpu_rst_n, 1);
    @(posedge clk);
    kick <= 4'h0;
    debug_mode <= 1'b0;
    wait_for(1, 1'b0, 20);
    chk("lockup spares wdt", watchdog_timer_rst_n, 1);
    wait_for(1, 1'b1, 60);
    rdchk("lockup cause", 12'h400, 32'h8);
    wr(12'h400, 32'hffff_ffff);
    pulse(4'h4);
    chk("dog spares swj", serial_debug_port_rst_n, 1);
    wait_for(1, 1'b1, 60);
    rdchk("dog cause", 12'h400, 32'h2);
    rdchk("retained cleared", 12'h51c, 32'h0);
    wr(12'h400, 32'hffff_ffff);
    wr(12'h900, 32'h0001_0001);
    for (int i = 0; i < 2; i++) begin
      wr(12'h500, 32'h1);
      debug_mode <= (i == 1);
      repeat (3) @(negedge clk);
      chk("ram access off", 32'(ram_accessible), 32'h0);
      chk("ram retain off", 32'(ram_retained), 32'h1);
      @(posedge clk);
      pin_detect <= 1'b1;
      wait_for(1, 1'b0, 20);
      chk("wake spares gpio", gpio_rst_n, 1);
      chk("wake debug", debug_rst_n, i);
      @(posedge clk);
      pin_detect <= 1'b0;
      debug_mode <= 1'b0;
      wait_for(1, 1'b1, 60);
      chk("on after wake", system_off, 0);
      rdchk("wake cause", 12'h400, 32'h0001_0000);
      rdchk("ram kept", 12'h900, 32'h0001_0001);
      wr(12'h400, 32'hffff_ffff);
    end
    wr(12'h200, 32'h4);
    gpio_pins[4] <= 1'b0;
    wait_for(1, 1'b0, 20);
    @(posedge clk);
    gpio_pins <= 8'hff;
    wait_for(1, 1'b1, 60);
    rdchk("pin cause", 12'h400, 32'h1);
    rdchk("pin select cleared", 12'h200, 32'h8000_0000);
    @(posedge clk);
    supply_below_brownout <= 1'b1;
    wait_for(1, 1'b0, 20);
    repeat (20) @(negedge clk);
    chk("brownout holds", cpu_rst_n, 0);
    chk("brownout swj", serial_debug_port_rst_n, 0);
    @(posedge clk);
    supply_below_brownout <= 1'b0;
    wait_for(1, 1'b1, 60);
    rdchk("brownout cause", 12'h400, 32'h0);
    give_verdict;
  end
endmodule
